// ### core/udc_pkg.sv
package udc_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] STAT_OFF = 12'h004;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CTRL_DEC_POS = 0;
  localparam int STAT_CNT_LSB = 0;
  localparam int STAT_CNT_MSB = 3;
  localparam int STAT_CARRY_POS = 4;
  localparam int STAT_UP_POS = 5;
  localparam int STAT_DEC_POS = 6;

  // ------------------------------------------------------------
  // reset values and count limits
  // ------------------------------------------------------------
  localparam logic CTRL_DEC_RST = 1'b0;
  localparam logic [3:0] COUNT_RST = 4'h0;
  localparam logic [3:0] COUNT_MIN = 4'h0;
  localparam logic [3:0] DEC_MAX = 4'h9;
  localparam logic [3:0] BIN_MAX = 4'hf;
  localparam logic [3:0] COUNT_ONE = 4'h1;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

endpackage

// ### core/udc_counter.sv
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
// Contract
// - four-bit state; decade mode counts 0..9, binary mode counts 0..15
// - all state bits update together on the rising clock edge
// - low preset at an edge loads the data inputs, counting suppressed
// - count advances only with both enables low and no preset
// - direction high increments, direction low decrements
// - chain enable gates the carry; carry active only while it is low
// - carry low when enabled and at zero down or maximum up
// - control changes leave the count alone until a clock edge
// - decade up from nine wraps to zero, then one, two
// - decade down from zero wraps to nine, then eight, seven
// - binary up from fifteen wraps to zero, then one, two
// - binary down from zero wraps to fifteen, then fourteen, thirteen

module udc_counter (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // counter controls
  input wire logic load_n,
  input wire logic [3:0] data_in,
  input wire logic parallel_count_enable_n,
  input wire logic chain_count_enable_n,
  input wire logic count_up,
  // counter outputs
  output logic [3:0] count_q,
  output logic ripple_carry_out_n
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [3:0] count_max(input logic dec);
    count_max = dec ? udc_pkg::DEC_MAX : udc_pkg::BIN_MAX;
  endfunction

  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = (a == udc_pkg::CTRL_OFF) || (a == udc_pkg::STAT_OFF);
  endfunction

  logic dec_mode_r;
  logic dec_mode_nxt;
  logic [3:0] count_r;
  logic [3:0] count_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic count_go;
  logic carry_hit;
  logic [3:0] max_val;

  // ------------------------------------------------------------
  // counter core
  // ------------------------------------------------------------
  assign max_val = count_max(dec_mode_r);
  assign count_go = load_n && !parallel_count_enable_n && !chain_count_enable_n;

  always_comb begin
    count_nxt = count_r;
    if (!load_n) begin
      count_nxt = data_in;
    end else if (count_go) begin
      if (count_up) begin
        if (count_r >= max_val) begin
          count_nxt = udc_pkg::COUNT_MIN;
        end else begin
          count_nxt = count_r + udc_pkg::COUNT_ONE;
        end
      end else begin
        if (count_r == udc_pkg::COUNT_MIN) begin
          count_nxt = max_val;
        end else begin
          count_nxt = count_r - udc_pkg::COUNT_ONE;
        end
      end
    end
  end

  // controls only matter as sampled here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= udc_pkg::COUNT_RST;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign count_q = count_r;

  // ------------------------------------------------------------
  // ripple carry
  // ------------------------------------------------------------
  always_comb begin
    if (count_up) begin
      carry_hit = (count_r == max_val);
    end else begin
      carry_hit = (count_r == udc_pkg::COUNT_MIN);
    end
  end

  assign ripple_carry_out_n = !(carry_hit && !chain_count_enable_n);

  // ------------------------------------------------------------
  // apb slave
  // ------------------------------------------------------------
  // read data is captured in setup, so every access ends after one access cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit(paddr);
  assign prdata = prdata_r;

  always_comb begin
    dec_mode_nxt = dec_mode_r;
    if (psel && penable && pwrite && pstrb[0] && (paddr == udc_pkg::CTRL_OFF)) begin
      dec_mode_nxt = pwdata[udc_pkg::CTRL_DEC_POS];
    end
  end

  always_comb begin
    prdata_nxt = prdata_r;
    if (psel && !penable && !pwrite) begin
      prdata_nxt = udc_pkg::RDATA_RST;
      if (paddr == udc_pkg::CTRL_OFF) begin
        prdata_nxt[udc_pkg::CTRL_DEC_POS] = dec_mode_r;
      end else if (paddr == udc_pkg::STAT_OFF) begin
        prdata_nxt[udc_pkg::STAT_CNT_MSB:udc_pkg::STAT_CNT_LSB] = count_r;
        prdata_nxt[udc_pkg::STAT_CARRY_POS] = !ripple_carry_out_n;
        prdata_nxt[udc_pkg::STAT_UP_POS] = count_up;
        prdata_nxt[udc_pkg::STAT_DEC_POS] = dec_mode_r;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_mode_r <= udc_pkg::CTRL_DEC_RST;
      prdata_r <= udc_pkg::RDATA_RST;
    end else begin
      dec_mode_r <= dec_mode_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic up_go;
  logic dn_go;
  logic mode_quiet;
  assign up_go = count_go && count_up;
  assign dn_go = count_go && !count_up;
  assign mode_quiet = !(psel && penable && pwrite);

  sequence s_up_run(logic dec);
    (up_go && mode_quiet && dec_mode_r == dec) [*3];
  endsequence

  sequence s_dn_run(logic dec);
    (dn_go && mode_quiet && dec_mode_r == dec) [*3];
  endsequence

  a_load_copy:
  assert property (!load_n |=> count_r == $past(data_in))
    else $error("preset did not load data inputs");

  a_hold_inhibit:
  assert property (load_n && (parallel_count_enable_n || chain_count_enable_n)
                   |=> $stable(count_r))
    else $error("count moved while inhibited");

  a_count_inc:
  assert property (up_go && count_r < max_val && mode_quiet
                   |=> count_r == $past(count_r) + 4'h1)
    else $error("count did not step up by one");

  a_count_dec:
  assert property (dn_go && count_r != 4'h0
                   |=> count_r == $past(count_r) - 4'h1)
    else $error("count did not step down by one");

  a_dec_up_wrap:
  assert property ((count_r == 4'h9) ##0 s_up_run(1'b1)
                   |=> count_r == 4'h2 ##0 $past(count_r) == 4'h1
                       ##0 $past(count_r, 2) == 4'h0)
    else $error("decade up wrap wrong");

  a_dec_dn_wrap:
  assert property ((count_r == 4'h0) ##0 s_dn_run(1'b1)
                   |=> count_r == 4'h7 ##0 $past(count_r) == 4'h8
                       ##0 $past(count_r, 2) == 4'h9)
    else $error("decade down wrap wrong");

  a_bin_up_wrap:
  assert property ((count_r == 4'hf) ##0 s_up_run(1'b0)
                   |=> count_r == 4'h2 ##0 $past(count_r) == 4'h1
                       ##0 $past(count_r, 2) == 4'h0)
    else $error("binary up wrap wrong");

  a_bin_dn_wrap:
  assert property ((count_r == 4'h0) ##0 s_dn_run(1'b0)
                   |=> count_r == 4'hd ##0 $past(count_r) == 4'he
                       ##0 $past(count_r, 2) == 4'hf)
    else $error("binary down wrap wrong");

  a_carry_gated:
  assert property (chain_count_enable_n |-> ripple_carry_out_n)
    else $error("carry active with chain enable high");

  a_carry_max:
  assert property (!chain_count_enable_n && count_up && dec_mode_r && count_r == 4'h9
                   |-> !ripple_carry_out_n)
    else $error("carry missing at decade maximum");

  a_carry_zero:
  assert property (!chain_count_enable_n && !count_up && count_r == 4'h0
                   |-> !ripple_carry_out_n)
    else $error("carry missing at zero counting down");

  a_carry_bin_max:
  assert property (!chain_count_enable_n && count_up && !dec_mode_r
                   && count_r == udc_pkg::BIN_MAX |-> !ripple_carry_out_n)
    else $error("carry missing at binary maximum");

  a_carry_up_off:
  assert property (count_up && count_r != udc_pkg::DEC_MAX && count_r != udc_pkg::BIN_MAX
                   |-> ripple_carry_out_n)
    else $error("carry active away from maximum");

  a_carry_dn_off:
  assert property (!count_up && count_r != udc_pkg::COUNT_MIN |-> ripple_carry_out_n)
    else $error("carry active away from zero");

  a_carry_dir:
  assert property (!chain_count_enable_n && count_r == udc_pkg::COUNT_MIN
                   |-> ripple_carry_out_n == count_up)
    else $error("carry does not follow direction at zero");

  a_dec_max_wrap:
  assert property (up_go && mode_quiet && dec_mode_r && count_r == udc_pkg::DEC_MAX
                   |=> count_r == udc_pkg::COUNT_MIN)
    else $error("decade count did not wrap up to zero");

  a_dec_high_wrap:
  assert property (up_go && mode_quiet && dec_mode_r && count_r > udc_pkg::DEC_MAX
                   |=> count_r == udc_pkg::COUNT_MIN)
    else $error("decade count above nine did not return to zero");

  a_dec_min_wrap:
  assert property (dn_go && mode_quiet && dec_mode_r && count_r == udc_pkg::COUNT_MIN
                   |=> count_r == udc_pkg::DEC_MAX)
    else $error("decade count did not wrap down to nine");

  a_bin_max_wrap:
  assert property (up_go && mode_quiet && !dec_mode_r && count_r == udc_pkg::BIN_MAX
                   |=> count_r == udc_pkg::COUNT_MIN)
    else $error("binary count did not wrap up to zero");

  a_bin_min_wrap:
  assert property (dn_go && mode_quiet && !dec_mode_r && count_r == udc_pkg::COUNT_MIN
                   |=> count_r == udc_pkg::BIN_MAX)
    else $error("binary count did not wrap down to fifteen");

  a_dec_range:
  assert property (count_go && mode_quiet && dec_mode_r && count_r <= udc_pkg::DEC_MAX
                   |=> count_r <= udc_pkg::DEC_MAX)
    else $error("decade count left zero to nine");

  a_mode_write:
  assert property (psel && penable && pwrite && pstrb[0] && paddr == udc_pkg::CTRL_OFF
                   |=> dec_mode_r == $past(pwdata[udc_pkg::CTRL_DEC_POS]))
    else $error("mode write did not take effect");

  a_mode_keep:
  assert property (!(psel && penable && pwrite && pstrb[0] && paddr == udc_pkg::CTRL_OFF)
                   |=> $stable(dec_mode_r))
    else $error("mode changed without a mode write");

  a_bus_error:
  assert property (psel && penable |-> pslverr == !(paddr == udc_pkg::CTRL_OFF
                   || paddr == udc_pkg::STAT_OFF))
    else $error("bus error response wrong");

  a_rdata_hold:
  assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data changed outside a read setup");

  a_apb_rdata:
  assert property (psel && !penable && !pwrite && paddr == udc_pkg::STAT_OFF
                   |=> prdata[3:0] == $past(count_r))
    else $error("status read does not show count");

endmodule

// ### sim/udc_cascade.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// next cascaded stage, enabled by the lower ripple carry
// ------------------------------------------------------------
module udc_cascade (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // enables from the lower stage and control logic
  input wire logic carry_in_n,
  input wire logic parallel_enable_n,
  input wire logic count_up,
  // upper nibble
  output logic [3:0] hi_q
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      hi_q <= 4'h0;
    else if (!carry_in_n && !parallel_enable_n)
      hi_q <= count_up ? hi_q + 4'h1 : hi_q - 4'h1;
  end
endmodule

// ### sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic load_n = 1'b1, pen_n = 1'b1, cen_n = 1'b1, count_up = 1'b1;
  logic dec = 1'b0, chk_on = 1'b0, pready, pslverr, rco_n, er;
  logic [11:0] paddr = 12'h000;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] data_in = 4'h0, exp_q = 4'h0, exp_h = 4'h0, count_q, hi_q;
  int fails = 0;
  int n_compared = 0;

  always #4 pclk = ~pclk;

  udc_counter i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .load_n(load_n), .data_in(data_in),
    .parallel_count_enable_n(pen_n), .chain_count_enable_n(cen_n), .count_up(count_up),
    .count_q(count_q), .ripple_carry_out_n(rco_n));
  udc_cascade i_next (.pclk(pclk), .presetn(presetn), .carry_in_n(rco_n),
    .parallel_enable_n(pen_n), .count_up(count_up), .hi_q(hi_q));

  // ------------------------------------------------------------
  // compare and report
  // ------------------------------------------------------------
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task test_done;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ------------------------------------------------------------
  // bus and counter drivers
  // ------------------------------------------------------------
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      fails++;
      test_done();
    end else begin
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task run(input logic ld, input logic [3:0] d, input logic p, t, u, input logic [3:0] e, h);
    load_n <= ld;
    data_in <= d;
    pen_n <= p;
    cen_n <= t;
    count_up <= u;
    @(posedge pclk);
    exp_q <= e;
    exp_h <= h;
  endtask

  always @(negedge pclk) begin
    if (chk_on) begin
      chk("count_q", 32'(exp_q), 32'(count_q));
      chk("hi_q", 32'(exp_h), 32'(hi_q));
      chk("carry_n", 32'(!(!cen_n && (count_up ? exp_q == (dec ? 4'h9 : 4'hf)
        : exp_q == 4'h0))), 32'(rco_n));
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    chk_on <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl", 32'h0, rd);
    apb(1'b1, 12'h004, 32'hff);
    chk("err_wr", 32'h0, 32'(er));
    apb(1'b0, 12'h004, 32'h0);
    chk("stat", 32'h20, rd);
    chk("err_rd", 32'h0, 32'(er));
    apb(1'b0, 12'h008, 32'h0);
    chk("err", 32'h1, 32'(er));
    chk("rd_bad", 32'h0, rd);
    run(0, 4'hd, 1, 1, 1, 4'hd, 4'h0);
    run(1, 4'h0, 0, 1, 1, 4'hd, 4'h0);
    run(1, 4'h0, 0, 0, 1, 4'he, 4'h0);
    run(1, 4'h0, 0, 0, 1, 4'hf, 4'h0);
    run(1, 4'h0, 0, 1, 1, 4'hf, 4'h0);
    run(1, 4'h0, 0, 0, 1, 4'h0, 4'h1);
    run(1, 4'h0, 0, 0, 1, 4'h1, 4'h1);
    run(1, 4'h0, 0, 0, 1, 4'h2, 4'h1);
    run(1, 4'h0, 1, 0, 0, 4'h2, 4'h1);
    run(1, 4'h0, 0, 0, 0, 4'h1, 4'h1);
    run(1, 4'h0, 0, 0, 0, 4'h0, 4'h1);
    run(1, 4'h0, 0, 0, 0, 4'hf, 4'h0);
    run(1, 4'h0, 0, 0, 0, 4'he, 4'h0);
    run(1, 4'h0, 0, 0, 0, 4'hd, 4'h0);
    run(1, 4'h0, 1, 1, 1, 4'hd, 4'h0);
    apb(1'b1, 12'h000, 32'h1);
    dec = 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl", 32'h1, rd);
    pstrb <= 4'h0;
    apb(1'b1, 12'h000, 32'h0);
    pstrb <= 4'hf;
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl_strb", 32'h1, rd);
    run(0, 4'h7, 1, 1, 1, 4'h7, 4'h0);
    run(1, 4'h0, 0, 0, 1, 4'h8, 4'h0);
    run(1, 4'h0, 0, 0, 1, 4'h9, 4'h0);
    run(1, 4'h0, 1, 0, 1, 4'h9, 4'h0);
    apb(1'b0, 12'h004, 32'h0);
    chk("stat", 32'h79, rd);
    run(1, 4'h0, 0, 0, 1, 4'h0, 4'h1);
    run(1, 4'h0, 0, 0, 1, 4'h1, 4'h1);
    run(1, 4'h0, 0, 0, 1, 4'h2, 4'h1);
    run(0, 4'hc, 1, 1, 1, 4'hc, 4'h1);
    run(1, 4'h0, 0, 0, 1, 4'h0, 4'h1);
    run(1, 4'h0, 0, 0, 1, 4'h1, 4'h1);
    run(0, 4'h1, 0, 0, 0, 4'h1, 4'h1);
    run(1, 4'h0, 0, 0, 0, 4'h0, 4'h1);
    run(1, 4'h0, 0, 0, 0, 4'h9, 4'h0);
    run(1, 4'h0, 0, 0, 0, 4'h8, 4'h0);
    run(1, 4'h0, 0, 0, 0, 4'h7, 4'h0);
    run(1, 4'h0, 1, 1, 0, 4'h7, 4'h0);
    @(posedge pclk);
    test_done();
  end
endmodule
